// ===== qawd_answer_checker.v
// qawd_answer_checker.v: answer comparison and status update of the
// question-and-answer watchdog, with its register port and interrupt.
// assumes window phase and time-out come from a window timer on clk,
// and the serial link decodes frames into single-cycle register strobes.
`timescale 1ns/1ps
`default_nettype none
`include "qawd_defines.vh"

module qawd_answer_checker (
    // clock and reset
    input wire clk,
    input wire nrst,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // window timer side
    input wire in_window2,
    input wire answer_timeout,
    // results toward the rest of the watchdog
    output reg [3:0] question,
    output reg [2:0] fail_counter,
    output reg [1:0] question_feedback_select,
    output reg [7:0] window1_duration_config,
    output reg [7:0] window2_duration_config,
    output reg sequence_start,
    // interrupt
    output wire irq
);

    reg [1:0] answer_byte_counter;
    reg answer_err;
    reg timeout_flag;
    reg answer_early_flag;
    reg sequence_error_flag;
    reg window_config_changed_flag;
    reg [`QAWD_IRQ_W-1:0] irq_status;
    reg [`QAWD_IRQ_W-1:0] irq_mask;

    reg [31:0] ref_word;
    reg [7:0] ref_byte;
    wire [7:0] answer_write_register;
    wire answer_wr;
    wire cfg_wr;
    wire byte_bad;
    wire final_byte;
    wire seq_bad;
    wire good_event;
    wire bad_event;
    reg [`QAWD_IRQ_W-1:0] next_irq_events;
    reg [31:0] next_rdata;
    wire [31:0] status_word;

    // reference bytes three..zero per question, default feedback only
    always @* begin
        case (question)
            4'h0: ref_word = 32'hFF0FF000;
            4'h1: ref_word = 32'hB040BF4F;
            4'h2: ref_word = 32'hE919E616;
            4'h3: ref_word = 32'hA656A959;
            4'h4: ref_word = 32'h75857A8A;
            4'h5: ref_word = 32'h3ACA35C5;
            4'h6: ref_word = 32'h63936C9C;
            4'h7: ref_word = 32'h2CDC23D3;
            4'h8: ref_word = 32'hD222DD2D;
            4'h9: ref_word = 32'h9D6D9262;
            4'hA: ref_word = 32'hC434CB3B;
            4'hB: ref_word = 32'h8B7B8474;
            4'hC: ref_word = 32'h58A857A7;
            4'hD: ref_word = 32'h17E718E8;
            4'hE: ref_word = 32'h4EBE41B1;
            4'hF: ref_word = 32'h01F10EFE;
            default: ref_word = 32'h00000000;
        endcase
    end

    // counter picks the expected byte out of the answer word
    always @* begin
        case (answer_byte_counter)
            `QAWD_CNT_BYTE3: ref_byte = ref_word[31:24];
            `QAWD_CNT_BYTE2: ref_byte = ref_word[23:16];
            `QAWD_CNT_BYTE1: ref_byte = ref_word[15:8];
            `QAWD_CNT_BYTE0: ref_byte = ref_word[7:0];
            default: ref_byte = ref_word[7:0];
        endcase
    end

    // decode of the two writes that drive the checker
    assign answer_write_register = reg_wdata[7:0];
    assign answer_wr = reg_wr && (reg_addr == `QAWD_OFF_ANSWER);
    assign cfg_wr = reg_wr && ((reg_addr == `QAWD_OFF_WIN1) || (reg_addr == `QAWD_OFF_WIN2));

    // a non-default feedback has no table here, so every byte counts as wrong
    assign byte_bad = (answer_write_register != ref_byte)
        || (question_feedback_select != `QAWD_FDBK_DEFAULT);
    assign final_byte = answer_wr && (answer_byte_counter == `QAWD_CNT_BYTE0);
    assign seq_bad = answer_err || byte_bad;

    // config write beats time-out, time-out beats a final answer byte
    assign good_event = final_byte && !cfg_wr && !answer_timeout && !seq_bad && in_window2;
    assign bad_event = final_byte && !cfg_wr && !answer_timeout && !good_event;

    // answer counter and running answer error
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            answer_byte_counter <= `QAWD_CNT_BYTE3;
            answer_err <= 1'b0;
        end else if (cfg_wr || answer_timeout || final_byte) begin
            answer_byte_counter <= `QAWD_CNT_BYTE3;
            answer_err <= 1'b0;
        end else if (answer_wr) begin
            answer_byte_counter <= answer_byte_counter - 2'h1;
            answer_err <= seq_bad;
        end
    end

    // sequence end: fail counter, question and sequence flags
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fail_counter <= `QAWD_RST_FAIL;
            question <= `QAWD_RST_QUESTION;
            sequence_error_flag <= 1'b0;
            answer_early_flag <= 1'b0;
            timeout_flag <= 1'b0;
            window_config_changed_flag <= 1'b0;
        end else if (cfg_wr) begin
            if (fail_counter != `QAWD_FAIL_MAX) begin
                fail_counter <= fail_counter + 3'h1;
            end
            window_config_changed_flag <= 1'b1;
            sequence_error_flag <= 1'b0;
            timeout_flag <= 1'b0;
            answer_early_flag <= 1'b0;
        end else if (answer_timeout) begin
            if (fail_counter != `QAWD_FAIL_MAX) begin
                fail_counter <= fail_counter + 3'h1;
            end
            timeout_flag <= 1'b1;
            sequence_error_flag <= answer_err;
            answer_early_flag <= 1'b0;
            window_config_changed_flag <= 1'b0;
        end else if (good_event) begin
            if (fail_counter != `QAWD_FAIL_MIN) begin
                fail_counter <= fail_counter - 3'h1;
            end
            question <= question + 4'h1;
            sequence_error_flag <= 1'b0;
            answer_early_flag <= 1'b0;
            timeout_flag <= 1'b0;
            window_config_changed_flag <= 1'b0;
        end else if (bad_event) begin
            if (fail_counter != `QAWD_FAIL_MAX) begin
                fail_counter <= fail_counter + 3'h1;
            end
            sequence_error_flag <= seq_bad;
            answer_early_flag <= !in_window2;
            timeout_flag <= 1'b0;
            window_config_changed_flag <= 1'b0;
        end
    end

    // one-cycle pulse telling the window timer a new sequence begins
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sequence_start <= 1'b0;
        end else begin
            sequence_start <= cfg_wr || answer_timeout || final_byte;
        end
    end

    // window configuration, feedback select and interrupt mask registers
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            window1_duration_config <= `QAWD_RST_WIN;
            window2_duration_config <= `QAWD_RST_WIN;
            question_feedback_select <= `QAWD_RST_FDBK;
            irq_mask <= `QAWD_RST_MASK;
        end else if (reg_wr) begin
            case (reg_addr)
                `QAWD_OFF_WIN1: window1_duration_config <= reg_wdata[7:0];
                `QAWD_OFF_WIN2: window2_duration_config <= reg_wdata[7:0];
                `QAWD_OFF_FDBK: question_feedback_select <= reg_wdata[1:0];
                `QAWD_OFF_IRQ_MASK: irq_mask <= reg_wdata[`QAWD_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // interrupt events of this cycle
    always @* begin
        next_irq_events = {`QAWD_IRQ_W{1'b0}};
        next_irq_events[`QAWD_IRQ_GOOD] = good_event;
        next_irq_events[`QAWD_IRQ_BAD] = bad_event;
        next_irq_events[`QAWD_IRQ_TIMEOUT] = answer_timeout && !cfg_wr;
        next_irq_events[`QAWD_IRQ_CFG] = cfg_wr;
    end

    // sticky status, write one to clear; a new event wins over its clear
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= {`QAWD_IRQ_W{1'b0}};
        end else if (reg_wr && (reg_addr == `QAWD_OFF_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~reg_wdata[`QAWD_IRQ_W-1:0]) | next_irq_events;
        end else begin
            irq_status <= irq_status | next_irq_events;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // watchdog status register image
    assign status_word = {21'h0, fail_counter, 1'b0, answer_byte_counter,
        window_config_changed_flag, sequence_error_flag, answer_early_flag,
        timeout_flag, answer_err};

    // read mux; unmapped offsets and the answer register read as zero
    always @* begin
        case (reg_addr)
            `QAWD_OFF_QUESTION: next_rdata = {28'h0000000, question};
            `QAWD_OFF_FDBK: next_rdata = {30'h0, question_feedback_select};
            `QAWD_OFF_WIN1: next_rdata = {24'h000000, window1_duration_config};
            `QAWD_OFF_WIN2: next_rdata = {24'h000000, window2_duration_config};
            `QAWD_OFF_STATUS: next_rdata = status_word;
            `QAWD_OFF_IRQ_STATUS: next_rdata = {28'h0000000, irq_status};
            `QAWD_OFF_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule // qawd_answer_checker
`default_nettype wire

// ===== qawd_answer_checker_asserts.sv
// qawd_answer_checker_asserts.sv: port checker for the answer checker.
// assumes one clk domain, nrst async low, at most one strobe per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "qawd_defines.vh"
module qawd_chk (
    // clock and reset
    input wire clk,
    input wire nrst,
    // register port and window timer
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire answer_timeout,
    // results
    input wire [3:0] question,
    input wire [2:0] fail_counter,
    input wire sequence_start
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [1:0] acnt;
    wire cfg_wr = reg_wr && (reg_addr == `QAWD_OFF_WIN1 || reg_addr == `QAWD_OFF_WIN2);
    wire ans_wr = reg_wr && reg_addr == `QAWD_OFF_ANSWER && !answer_timeout;
    wire end_ev = cfg_wr || answer_timeout || (ans_wr && acnt == 2'h0);
    function automatic [2:0] up(input [2:0] f);
        up = (f == 3'h7) ? f : f + 3'h1;
    endfunction
    function automatic [2:0] dn(input [2:0] f);
        dn = (f == 3'h0) ? f : f - 3'h1;
    endfunction
    // shadow byte counter, so mid bytes are told from the last one
    always @(posedge clk or negedge nrst) begin
        if (!nrst) acnt <= 2'h3;
        else if (cfg_wr || answer_timeout) acnt <= 2'h3;
        else if (ans_wr) acnt <= acnt - 2'h1;
    end
    sequence s_last; ans_wr && acnt == 2'h0; endsequence
    sequence s_mid; ans_wr && acnt != 2'h0; endsequence
    last_end_a: assert property (s_last |=> sequence_start)
        else $error("no start after last byte");
    mid_hold_a: assert property (s_mid |=> !sequence_start)
        else $error("start after a middle byte");
    cfg_end_a: assert property (cfg_wr |=> sequence_start && $stable(question))
        else $error("config write mishandled");
    tout_end_a: assert property (answer_timeout |=> sequence_start && $stable(question))
        else $error("time-out mishandled");
    good_step_a: assert property (sequence_start && question != $past(question) |->
        question == $past(question) + 4'h1 && fail_counter == dn($past(fail_counter)))
        else $error("good end wrong");
    bad_step_a: assert property (sequence_start && question == $past(question) |->
        fail_counter == up($past(fail_counter)))
        else $error("bad end fail count wrong");
    start_cause_a: assert property (sequence_start |-> $past(end_ev))
        else $error("start without an end");
    quiet_hold_a: assert property (!sequence_start |->
        $stable(question) && $stable(fail_counter))
        else $error("results moved between ends");
endmodule // qawd_chk
bind qawd_answer_checker qawd_chk u_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .answer_timeout(answer_timeout), .question(question),
    .fail_counter(fail_counter), .sequence_start(sequence_start));
`default_nettype wire

// ===== qawd_defines.vh
// qawd_defines.vh: register offsets, field positions, reset values and
// counter codes for the question-and-answer watchdog answer checker.
// assumes an 8-bit byte address on the plain register port, 32-bit data.
`ifndef QAWD_DEFINES_VH
`define QAWD_DEFINES_VH

// register byte offsets
`define QAWD_OFF_ANSWER 8'h00
`define QAWD_OFF_QUESTION 8'h04
`define QAWD_OFF_FDBK 8'h08
`define QAWD_OFF_WIN1 8'h0C
`define QAWD_OFF_WIN2 8'h10
`define QAWD_OFF_STATUS 8'h14
`define QAWD_OFF_IRQ_STATUS 8'h18
`define QAWD_OFF_IRQ_MASK 8'h1C

// status register fields
`define QAWD_ST_ANSWER_ERR 0
`define QAWD_ST_TIMEOUT 1
`define QAWD_ST_EARLY 2
`define QAWD_ST_SEQUENCE_ERROR_FLAG 3
`define QAWD_ST_CFG_CHG 4
`define QAWD_ST_CNT_LSB 5
`define QAWD_ST_CNT_MSB 6
`define QAWD_ST_FAIL_LSB 8
`define QAWD_ST_FAIL_MSB 10

// interrupt status and mask fields
`define QAWD_IRQ_GOOD 0
`define QAWD_IRQ_BAD 1
`define QAWD_IRQ_TIMEOUT 2
`define QAWD_IRQ_CFG 3
`define QAWD_IRQ_W 4

// answer byte counter codes
`define QAWD_CNT_BYTE3 2'h3
`define QAWD_CNT_BYTE2 2'h2
`define QAWD_CNT_BYTE1 2'h1
`define QAWD_CNT_BYTE0 2'h0

// fail counter limits
`define QAWD_FAIL_MAX 3'h7
`define QAWD_FAIL_MIN 3'h0

// reset values
`define QAWD_RST_FAIL 3'h0
`define QAWD_RST_QUESTION 4'h0
`define QAWD_RST_FDBK 2'h0
`define QAWD_RST_WIN 8'h00
`define QAWD_RST_MASK 4'h0

// default feedback setting, the only one the reference table covers
`define QAWD_FDBK_DEFAULT 2'h0

`endif

// ===== qawd_mcu.sv
// qawd_mcu.sv: microcontroller model writing answers over the register port.
// assumes its tasks are called from one bench process after reset.
`timescale 1ns/1ps
`default_nettype none
module qawd_mcu (
    // clock
    input wire clk,
    // register port
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire [31:0] reg_rdata
);
    // bytes three..zero per question, question f first
    localparam [127:0] T3 = 128'h01F10EFE_4EBE41B1_17E718E8_58A857A7;
    localparam [127:0] T2 = 128'h8B7B8474_C434CB3B_9D6D9262_D222DD2D;
    localparam [127:0] T1 = 128'h2CDC23D3_63936C9C_3ACA35C5_75857A8A;
    localparam [127:0] T0 = 128'hA656A959_E919E616_B040BF4F_FF0FF000;
    localparam [511:0] TBL = {T3, T2, T1, T0};
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // released lines are inverted so stale values never look valid
    task automatic wr(input [7:0] a, input [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask
    task automatic rd(input [7:0] a, output [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 v = reg_rdata;
    endtask
    // bytes hi down to lo in order; byte bad gets flipped bits
    task automatic send(input [3:0] q, input int hi, input int lo, input int bad);
        int k;
        for (k = hi; k >= lo; k--)
            wr(8'h00, {24'h0, TBL[q * 32 + k * 8 +: 8] ^ ((k == bad) ? 8'h5A : 8'h00)});
    endtask
endmodule // qawd_mcu
`default_nettype wire

// ===== tb.sv
// tb.sv: self-checking bench for the answer checker, corner and random runs.
// assumes the mcu model owns the register port; window and time-out from here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb;
    logic clk, nrst, in_window2, answer_timeout;
    wire [7:0] reg_addr, w1, w2c;
    wire [1:0] fsel;
    wire [31:0] reg_wdata, reg_rdata;
    wire reg_wr, reg_rd, sequence_start, irq;
    wire [3:0] question;
    wire [2:0] fail_counter;
    int fail_count, check_count, cyc, i;
    logic [2:0] ef;
    logic [3:0] eq;
    logic [31:0] d, lf;
    qawd_answer_checker dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .in_window2(in_window2), .answer_timeout(answer_timeout), .question(question),
        .fail_counter(fail_counter), .question_feedback_select(fsel),
        .window1_duration_config(w1), .window2_duration_config(w2c),
        .sequence_start(sequence_start), .irq(irq));
    qawd_mcu mcu (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard, far above the several hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            wrap_up;
        end
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic [2:0] up(input [2:0] f);
        up = (f == 3'h7) ? f : f + 3'h1;
    endfunction
    // one step of the stimulus shift register, taps 32 22 2 1
    function automatic [31:0] lfsr_step(input [31:0] s);
        lfsr_step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic st(input [3:0] f);
        mcu.rd(8'h14, d);
        `CHK("flags", f, d[4:1])
        `CHK("count", 2'h3, d[6:5])
        `CHK("fail", ef, d[10:8])
        `CHK("fail port", ef, fail_counter)
        `CHK("question", eq, question)
    endtask
    // whole answer: bad byte index, 4 for none; w2 is window at byte zero
    task automatic seq(input int bad, input bit w2);
        mcu.send(eq, 3, 1, bad);
        mcu.rd(8'h14, d);
        `CHK("mid count", 2'h0, d[6:5])
        `CHK("answer err", bad > 0 && bad < 4, d[0])
        in_window2 <= w2;
        mcu.send(eq, 0, 0, bad);
        if (bad == 4 && w2) begin
            ef = (ef == 3'h0) ? ef : ef - 3'h1;
            eq = eq + 4'h1;
        end else ef = up(ef);
        st({1'b0, bad != 4, !w2, 1'b0});
    endtask
    initial begin
        {nrst, in_window2, answer_timeout, fail_count, check_count, cyc} = '0;
        ef = 3'h0;
        eq = 4'h0;
        lf = 32'hE6EE7D7A;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        st(4'h0);
        mcu.rd(8'h40, d);
        `CHK("unmapped", 32'h0, d)
        mcu.wr(8'h1C, 32'hF);
        seq(4, 1);
        `CHK("irq", 1'b1, irq)
        mcu.wr(8'h18, 32'hF);
        #1 `CHK("irq clear", 1'b0, irq)
        seq(4, 0);
        for (i = 0; i < 4; i++) seq(i, i[0]);
        // time-out after two bytes, one of them wrong or not
        for (i = 0; i < 2; i++) begin
            mcu.send(eq, 3, 2, i ? 3 : 4);
            answer_timeout <= 1'b1;
            @(posedge clk);
            answer_timeout <= 1'b0;
            ef = up(ef);
            st({1'b0, i[0], 1'b0, 1'b1});
        end
        for (i = 0; i < 2; i++) begin
            mcu.send(eq, 3, 3, 4);
            mcu.wr(i ? 8'h10 : 8'h0C, 32'hA5);
            ef = up(ef);
            st(4'h8);
        end
        `CHK("win1", 8'hA5, w1)
        `CHK("win2", 8'hA5, w2c)
        mcu.rd(8'h18, d);
        `CHK("irq events", 4'hE, d[3:0])
        // non-default feedback has no table, so a right answer still fails
        mcu.wr(8'h08, 32'h1);
        #1 `CHK("fdbk", 2'h1, fsel)
        in_window2 <= 1'b1;
        mcu.send(eq, 3, 0, 4);
        mcu.wr(8'h08, 32'h0);
        ef = up(ef);
        st(4'h4);
        repeat (8) seq(1, 1);
        for (i = 0; i < 40; i++) begin
            lf = lfsr_step(lf);
            seq(lf[2:0] > 3'h4 ? 4 : int'(lf[2:0]), lf[3]);
        end
        repeat (8) seq(4, 1);
        // two edges in reset, so no sampled history spans the release
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        ef = 3'h0;
        eq = 4'h0;
        st(4'h0);
        wrap_up;
    end
endmodule // tb
`default_nettype wire
